// ==== common/clkdist_pkg.sv ====
// constants and types shared by the column clock and set/reset distribution
// ============================================================================
package clkdist_pkg;

  // ==========================================================================
  // array shape
  localparam int GCK_N = 8;
  localparam int FCK_PER_EDGE = 2;
  localparam int CELLS_PER_SECTOR = 4;
  localparam int COL_MAX = 12;
  localparam int SEC_MAX = 48;
  localparam int SYNC_STAGES = 2;

  // index of each clock pin in the synchronised pin vector
  localparam int IDX_FCK_LA = GCK_N;
  localparam int IDX_FCK_LB = GCK_N + 1;
  localparam int IDX_FCK_RA = GCK_N + 2;
  localparam int IDX_FCK_RB = GCK_N + 3;
  localparam int PIN_N = GCK_N + 2 * FCK_PER_EDGE;

  // ==========================================================================
  // avalon register map (byte addresses)
  localparam int AV_AW = 8;
  localparam int AV_DW = 32;
  localparam logic [AV_AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AV_AW-1:0] OFS_CELLQ = 8'h04;
  localparam logic [AV_AW-1:0] OFS_SETVAL = 8'h08;
  localparam logic [AV_AW-1:0] OFS_COL_BASE = 8'h10;
  localparam logic [AV_AW-1:0] OFS_SEC_BASE = 8'h40;

  // field positions
  localparam int CTRL_DONE_BIT = 0;
  localparam int COL_SEL_LSB = 0;
  localparam int COL_SEL_W = 4;
  localparam int SEC_CFG_LSB = 0;
  localparam logic [COL_SEL_W-1:0] SEL_FAST_A = 4'h8;
  localparam logic [COL_SEL_W-1:0] SEL_FAST_B = 4'h9;

  // ==========================================================================
  // types
  typedef enum logic [1:0]
  {
    CLK_OFF  = 2'b00,
    CLK_TRUE = 2'b01,
    CLK_INV  = 2'b10
  } clk_mode_t;

  typedef struct packed
  {
    logic sr_inv;
    logic sr_src;
    logic clk_src;
    clk_mode_t clk_mode;
  } sec_cfg_t;

  typedef struct packed
  {
    logic [AV_AW-1:0] address;
    logic read;
    logic write;
    logic [AV_DW-1:0] writedata;
  } av_req_t;

  // ==========================================================================
  // reset values
  localparam logic [COL_SEL_W-1:0] COL_SEL_RST = 4'h0;
  localparam sec_cfg_t SEC_CFG_RST = '{sr_inv: 1'b0, sr_src: 1'b0, clk_src: 1'b0,
                                       clk_mode: CLK_OFF};
  localparam logic SET_VAL_RST = 1'b0;
  localparam logic CELL_Q_RST = 1'b1;
  localparam logic PIN_SYNC_RST = 1'b0;
  localparam logic GSR_SYNC_RST = 1'b1;

endpackage

// ==== core/column_clock_and_set_reset_distribution.sv ====
// column clock muxes, configuration registers and sectors of the cell array
`timescale 1ns/1ps
module column_clock_and_set_reset_distribution
  import clkdist_pkg::*;
#(
  parameter int NCOL = 4,
  parameter int SEC_PER_COL = 2
)
(
  // clock, reset and enable
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // avalon-mm slave
  input wire av_req_t av_req,
  output logic [AV_DW-1:0] av_readdata,
  output logic av_waitrequest,
  // clock pins
  input wire logic [GCK_N-1:0] global_clock_lines,
  input wire logic fast_clock_left_a,
  input wire logic fast_clock_left_b,
  input wire logic fast_clock_right_a,
  input wire logic fast_clock_right_b,
  // global set/reset pin
  input wire logic global_set_reset_pin,
  // express routing lines, one per sector
  input wire logic [NCOL*SEC_PER_COL-1:0] plane4_express,
  input wire logic [NCOL*SEC_PER_COL-1:0] plane5_express,
  // cell registers
  input wire logic [NCOL*SEC_PER_COL*CELLS_PER_SECTOR-1:0] cell_d,
  output logic [NCOL*SEC_PER_COL*CELLS_PER_SECTOR-1:0] cell_q,
  // status
  output logic [NCOL-1:0] column_clock,
  output logic config_done
);

  // cells are numbered sector by sector, four to a sector
  localparam int NSEC = NCOL * SEC_PER_COL;
  localparam int NCELL = NSEC * CELLS_PER_SECTOR;

  // ==========================================================================
  // elaboration checks
  // the register map has fixed room for COL_MAX columns and SEC_MAX sectors
  generate
    if (NCOL < 2 || NCOL > COL_MAX)
    begin : g_bad_ncol
      $error("column count out of range of the register map");
    end
    if (SEC_PER_COL < 1 || NSEC > SEC_MAX)
    begin : g_bad_nsec
      $error("sector count out of range of the register map");
    end
    if (NCELL > AV_DW)
    begin : g_bad_ncell
      $error("cell count exceeds one data word");
    end
    // the select decode reads three bits of the code for a global line
    if (GCK_N != 8 || SEL_FAST_A < COL_SEL_W'(GCK_N))
    begin : g_bad_gck
      $error("global clock count does not fit the column select decode");
    end
    // every field is read back whole from one data word
    if (SEC_CFG_LSB + $bits(sec_cfg_t) > AV_DW || COL_SEL_LSB + COL_SEL_W > AV_DW)
    begin : g_bad_field
      $error("configuration field does not fit one data word");
    end
  endgenerate

  // ==========================================================================
  // state
  // the block state outside the sectors is one record, so reset and ce treat every field alike
  typedef struct packed
  {
    logic [PIN_N-1:0] pin_s1;
    logic [PIN_N-1:0] pin_s2;
    logic gsr_s1;
    logic gsr_s2;
    logic [NCOL-1:0][COL_SEL_W-1:0] col_sel;
    sec_cfg_t [NSEC-1:0] sec_cfg;
    logic [NCELL-1:0] set_val;
    logic done;
    logic [NCOL-1:0] col_clk;
    logic [AV_DW-1:0] rdata;
    logic waitrequest;
  } state_t;

  // reset leaves every sector clock off and every set/reset source on the global line
  localparam state_t ST_RST = '{
    pin_s1: {PIN_N{PIN_SYNC_RST}},
    pin_s2: {PIN_N{PIN_SYNC_RST}},
    gsr_s1: GSR_SYNC_RST,
    gsr_s2: GSR_SYNC_RST,
    col_sel: {NCOL{COL_SEL_RST}},
    sec_cfg: {NSEC{SEC_CFG_RST}},
    set_val: {NCELL{SET_VAL_RST}},
    done: 1'b0,
    col_clk: '0,
    rdata: '0,
    waitrequest: 1'b1
  };

  state_t st_ff;
  state_t nxt_st;
  logic [AV_DW-1:0] rd_word;
  logic [NCOL-1:0] col_hit;
  logic [NSEC-1:0] sec_hit;
  logic [NCOL-1:0] col_next;

  // ==========================================================================
  // column clock mux
  // only the edge columns decode the fast-clock codes; elsewhere they give 0
  // codes 10 to 15 are spare and deliver a still clock on every column
  function automatic logic col_pick(
    input int c,
    input logic [COL_SEL_W-1:0] sel,
    input logic [PIN_N-1:0] pins
  );
    logic r;
    r = 1'b0;
    if (sel < COL_SEL_W'(GCK_N))
    begin
      r = pins[sel[2:0]];
    end
    else if (c == 0 && sel == SEL_FAST_A)
    begin
      r = pins[IDX_FCK_LA];
    end
    else if (c == 0 && sel == SEL_FAST_B)
    begin
      r = pins[IDX_FCK_LB];
    end
    else if (c == NCOL - 1 && sel == SEL_FAST_A)
    begin
      r = pins[IDX_FCK_RA];
    end
    else if (c == NCOL - 1 && sel == SEL_FAST_B)
    begin
      r = pins[IDX_FCK_RB];
    end
    return r;
  endfunction

  // ==========================================================================
  // per-column and per-sector decode
  // the column clock is a registered copy of a synchronised pin, three mclk edges
  // behind it, so only pin rates well below half of mclk come through intact
  generate
    for (genvar c = 0; c < NCOL; c++)
    begin : g_col
      assign col_hit[c] = av_req.address == OFS_COL_BASE + AV_AW'(4 * c);
      assign col_next[c] = col_pick(c, st_ff.col_sel[c], st_ff.pin_s2);
    end
    for (genvar s = 0; s < NSEC; s++)
    begin : g_sec_dec
      assign sec_hit[s] = av_req.address == OFS_SEC_BASE + AV_AW'(4 * s);
    end
  endgenerate

  // ==========================================================================
  // register read decode
  // read data are decoded while the request waits and captured at the edge that drops waitrequest, one edge before it is accepted
  always_comb
  begin
    rd_word = '0;
    if (av_req.address == OFS_CTRL)
    begin
      rd_word[CTRL_DONE_BIT] = st_ff.done;
    end
    if (av_req.address == OFS_CELLQ)
    begin
      rd_word[NCELL-1:0] = cell_q;
    end
    if (av_req.address == OFS_SETVAL)
    begin
      rd_word[NCELL-1:0] = st_ff.set_val;
    end
    for (int c = 0; c < NCOL; c++)
    begin
      if (col_hit[c])
      begin
        rd_word[COL_SEL_LSB +: COL_SEL_W] = st_ff.col_sel[c];
      end
    end
    for (int s = 0; s < NSEC; s++)
    begin
      if (sec_hit[s])
      begin
        rd_word[SEC_CFG_LSB +: $bits(sec_cfg_t)] = st_ff.sec_cfg[s];
      end
    end
  end

  // ==========================================================================
  // next state
  always_comb
  begin
    nxt_st = st_ff;
    // pins come from outside mclk: two flops before any use
    nxt_st.pin_s1 = {fast_clock_right_b, fast_clock_right_a,
                     fast_clock_left_b, fast_clock_left_a, global_clock_lines};
    nxt_st.pin_s2 = st_ff.pin_s1;
    nxt_st.gsr_s1 = global_set_reset_pin;
    nxt_st.gsr_s2 = st_ff.gsr_s1;

    nxt_st.col_clk = col_next;

    // one wait state: the answer stands on the cycle waitrequest is low
    // a request seen while waitrequest is low is the tail of the one just answered
    nxt_st.waitrequest = 1'b1;
    if ((av_req.read || av_req.write) && st_ff.waitrequest)
    begin
      nxt_st.waitrequest = 1'b0;
      // a write answer leaves readdata as it was
      if (av_req.read)
      begin
        nxt_st.rdata = rd_word;
      end
    end

    // a write lands at the edge where waitrequest is sampled low, never earlier
    if (av_req.write && !st_ff.waitrequest)
    begin
      // writing 0 to done does nothing; only rstn clears the flag
      if (av_req.address == OFS_CTRL && av_req.writedata[CTRL_DONE_BIT])
      begin
        nxt_st.done = 1'b1;
      end
      // configuration is frozen once done; only a reset reopens it
      if (!st_ff.done)
      begin
        if (av_req.address == OFS_SETVAL)
        begin
          nxt_st.set_val = av_req.writedata[NCELL-1:0];
        end
        for (int c = 0; c < NCOL; c++)
        begin
          if (col_hit[c])
          begin
            nxt_st.col_sel[c] = av_req.writedata[COL_SEL_LSB +: COL_SEL_W];
          end
        end
        for (int s = 0; s < NSEC; s++)
        begin
          if (sec_hit[s])
          begin
            nxt_st.sec_cfg[s] =
              sec_cfg_t'(av_req.writedata[SEC_CFG_LSB +: $bits(sec_cfg_t)]);
          end
        end
      end
    end
  end

  // ==========================================================================
  // state register
  // ce low freezes the bus handshake too, so a waiting master simply waits longer
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_ff <= ST_RST;
    end
    else if (ce)
    begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // sectors: one global set/reset fans out to every column
  // sector s sits in column s / SEC_PER_COL, so the sectors of one column are
  // neighbours in cell_d and cell_q
  generate
    for (genvar s = 0; s < NSEC; s++)
    begin : g_sec
      localparam int SEC_COL = s / SEC_PER_COL;
      sector_cells sector_cells_inst
      (
        .mclk(mclk),
        .rstn(rstn),
        .ce(ce),
        .cfg(st_ff.sec_cfg[s]),
        .done(st_ff.done),
        .set_val(st_ff.set_val[s*CELLS_PER_SECTOR +: CELLS_PER_SECTOR]),
        .col_clk(st_ff.col_clk[SEC_COL]),
        .plane4(plane4_express[s]),
        .plane5(plane5_express[s]),
        .gsr(st_ff.gsr_s2),
        .d(cell_d[s*CELLS_PER_SECTOR +: CELLS_PER_SECTOR]),
        .q(cell_q[s*CELLS_PER_SECTOR +: CELLS_PER_SECTOR])
      );
    end
  endgenerate

  // ==========================================================================
  // outputs
  // cell_q comes from the sector registers and every other output is a field of the state register, so none can glitch
  assign av_readdata = st_ff.rdata;
  assign av_waitrequest = st_ff.waitrequest;
  assign column_clock = st_ff.col_clk;
  assign config_done = st_ff.done;

endmodule

// ==== core/sector_cells.sv ====
// one sector of four cell registers with its clock and set/reset muxes
`timescale 1ns/1ps
module sector_cells
  import clkdist_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // configuration
  input wire sec_cfg_t cfg,
  input wire logic done,
  input wire logic [CELLS_PER_SECTOR-1:0] set_val,
  // distributed signals
  input wire logic col_clk,
  input wire logic plane4,
  input wire logic plane5,
  input wire logic gsr,
  // cells
  input wire logic [CELLS_PER_SECTOR-1:0] d,
  output logic [CELLS_PER_SECTOR-1:0] q
);

  // ==========================================================================
  // state
  typedef struct packed
  {
    logic dclk;
    logic done_d;
    logic [CELLS_PER_SECTOR-1:0] q;
  } sec_st_t;

  localparam sec_st_t ST_RST = '{dclk: 1'b0, done_d: 1'b0,
                                 q: {CELLS_PER_SECTOR{CELL_Q_RST}}};

  sec_st_t st_ff;
  sec_st_t nxt_st;
  logic clk_src;
  logic sr_src;
  logic sr_lvl;

  // ==========================================================================
  // next state
  always_comb
  begin
    nxt_st = st_ff;
    clk_src = cfg.clk_src ? plane4 : col_clk;
    case (cfg.clk_mode)
      CLK_TRUE: nxt_st.dclk = clk_src;
      CLK_INV: nxt_st.dclk = ~clk_src;
      default: nxt_st.dclk = 1'b0;
    endcase
    if (!done)
    begin
      nxt_st.dclk = 1'b0;
    end
    nxt_st.done_d = done;
    sr_src = cfg.sr_src ? plane5 : gsr;
    sr_lvl = cfg.sr_inv ? ~sr_src : sr_src;
    // set/reset outranks the clock, as a real async set/reset would
    if (!done)
    begin
      nxt_st.q = {CELLS_PER_SECTOR{CELL_Q_RST}};
    end
    else if (!st_ff.done_d)
    begin
      nxt_st.q = set_val;
    end
    else if (!sr_lvl)
    begin
      nxt_st.q = set_val;
    end
    else if (nxt_st.dclk && !st_ff.dclk)
    begin
      nxt_st.q = d;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_ff <= ST_RST;
    end
    else if (ce)
    begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.q;

endmodule

// ==== tb/clkdist_chk.sv ====
// checker for bus handshake, cell outputs and configuration flag
`timescale 1ns/1ps
module clkdist_chk
  import clkdist_pkg::*;
#(
  parameter int NCOL = 4,
  parameter int SEC_PER_COL = 2
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // bus
  input wire av_req_t av_req,
  input wire logic [AV_DW-1:0] av_readdata,
  input wire logic av_waitrequest,
  // cells and status
  input wire logic [NCOL*SEC_PER_COL*CELLS_PER_SECTOR-1:0] cell_q,
  input wire logic config_done
);
  // ==========================================================================
  // properties
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  wire logic req = av_req.read | av_req.write;
  wire logic done_wr = av_req.write & av_req.writedata[CTRL_DONE_BIT] & ~av_waitrequest
                       & (av_req.address == OFS_CTRL);
  wire logic q_rd = av_req.read & (av_req.address == OFS_CELLQ);

  AST_WAIT_ONE: assert property (req && av_waitrequest |=> !av_waitrequest)
    else $error("no answer one cycle after request");
  AST_WAIT_PULSE: assert property (!av_waitrequest |=> av_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_WAIT_CAUSE: assert property ($fell(av_waitrequest) |-> $past(req))
    else $error("answer without request");
  AST_PRE_DONE: assert property (!config_done |-> &cell_q)
    else $error("cell output not all ones before done");
  AST_DONE_STICKY: assert property (config_done |=> config_done)
    else $error("done flag dropped");
  AST_DONE_CAUSE: assert property ($rose(config_done) |-> $past(done_wr))
    else $error("done flag rose without control write");
  AST_CELLQ_READ: assert property (!av_waitrequest && $past(q_rd)
    |-> av_readdata == 32'($past(cell_q)))
    else $error("cell readback differs from cell outputs");
  AST_RDATA_HOLD: assert property (av_waitrequest |-> $stable(av_readdata))
    else $error("read data moved outside an answer");

  cover property ($rose(config_done));
  cover property (q_rd && !av_waitrequest);
  cover property ($fell(cell_q[0]));
endmodule

// ==== tb/pin_clock_source.sv ====
// slow waveforms for the global and fast clock pins
`timescale 1ns/1ps
module pin_clock_source
  import clkdist_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // pins, fast order left a, left b, right a, right b
  output logic [GCK_N-1:0] global_clock_lines,
  output logic [3:0] fast_clock_pins,
  output logic [1:0] phase
);
  // ==========================================================================
  // waveforms
  logic [7:0] cnt_ff;
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn)
      cnt_ff <= 8'h00;
    else
      cnt_ff <= cnt_ff + 8'h01;
  // pins move only when phase wraps, so the bench knows when the sync chain has settled
  always_comb
  begin
    for (int i = 0; i < GCK_N; i++)
      global_clock_lines[i] = cnt_ff[2 + i / 2] ^ i[0];
    fast_clock_pins = {~cnt_ff[7], cnt_ff[7], ~cnt_ff[6], cnt_ff[6]};
  end
  assign phase = cnt_ff[1:0];
endmodule

// ==== tb/test_column_clock_and_set_reset_distribution.sv ====
// self-checking bench for the column clock and set/reset distribution
`timescale 1ns/1ps
module test_column_clock_and_set_reset_distribution;
  import clkdist_pkg::*;
  // ==========================================================================
  // signals
  localparam int NCOL = 4;
  localparam int SEC_PER_COL = 2;
  // s0 p4 true, s1 p4 inv, s2 off, s3 code 3, s4 p5, s5 p5 inv, s6 global, s7 global inv
  localparam logic [39:0] SEC_TBL = {5'h15, 5'h05, 5'h1d, 5'h0d, 5'h07, 5'h04, 5'h06, 5'h05};
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  av_req_t av_req = '0;
  logic [31:0] av_readdata, cell_q, sv, d1, exp;
  logic [31:0] cell_d = 32'h0;
  logic av_waitrequest, config_done;
  logic [GCK_N-1:0] gck;
  logic [3:0] fck;
  logic [1:0] phase;
  logic [NCOL-1:0] column_clock;
  logic ce = 1'b1;
  logic gsr_pin = 1'b1;
  logic [7:0] p4 = 8'h02;
  logic [7:0] p5 = 8'hdf;
  logic [31:0] exp_q[$];
  int seed = 32'h9f57;
  int num_errors = 0;
  int n_tests = 0;
  always #12.5 mclk = ~mclk;

  column_clock_and_set_reset_distribution #(.NCOL(NCOL), .SEC_PER_COL(SEC_PER_COL))
    column_clock_and_set_reset_distribution_inst (.mclk(mclk), .rstn(rstn), .ce(ce),
    .av_req(av_req), .av_readdata(av_readdata), .av_waitrequest(av_waitrequest),
    .global_clock_lines(gck), .fast_clock_left_a(fck[0]), .fast_clock_left_b(fck[1]),
    .fast_clock_right_a(fck[2]), .fast_clock_right_b(fck[3]),
    .global_set_reset_pin(gsr_pin), .plane4_express(p4), .plane5_express(p5),
    .cell_d(cell_d), .cell_q(cell_q), .column_clock(column_clock), .config_done(config_done));
  pin_clock_source pin_clock_source_inst (.mclk(mclk), .rstn(rstn),
    .global_clock_lines(gck), .fast_clock_pins(fck), .phase(phase));

  // ==========================================================================
  // tasks
  task automatic check(input string name, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, s);
    end
  endtask

  task automatic final_report();
    if (num_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge mclk);
    av_req <= '{address: a, read: !wr, write: wr, writedata: wd};
    for (n = 0; n < 20; n++)
    begin
      @(posedge mclk);
      if (!av_waitrequest)
        break;
    end
    if (n == 20)
    begin
      num_errors++;
      final_report();
    end
    av_req.read <= 1'b0;
    av_req.write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  // phase 3 means three edges since the pins moved
  task automatic col_check(input int c, input logic [3:0] s);
    logic e;
    bus(1'b1, OFS_COL_BASE + 8'(4 * c), 32'(s));
    for (int n = 0; n < 9; n++)
    begin
      @(posedge mclk);
      #1;
      if (n > 0 && phase === 2'h3)
        break;
    end
    e = s < 8 ? gck[s[2:0]] : c == 0 && s < 10 ? fck[s - SEL_FAST_A] :
        c == NCOL - 1 && s < 10 ? fck[s - SEL_FAST_A + 2] : 1'b0;
    check("column_clock", 32'(e), 32'(column_clock[c]));
  endtask

  always @(posedge mclk)
    if (rstn && av_req.read && !av_waitrequest)
      check("readdata", exp_q.pop_front(), av_readdata);

  // ==========================================================================
  // sequence
  initial
  begin
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    rd(OFS_CELLQ, 32'hffffffff);
    rd(OFS_SEC_BASE, 32'h0);
    rd(8'h0c, 32'h0);
    for (int k = 0; k < 4; k++)
      col_check(k[0] ? NCOL - 1 : 0, k[1] ? SEL_FAST_B : SEL_FAST_A);
    col_check(1, SEL_FAST_A);
    repeat (12)
      col_check({$random(seed)} % NCOL, 4'({$random(seed)} % 12));
    // column 0 follows a pin that moves every four edges; ce low must hold it still
    col_check(0, 4'h0);
    d1 = 32'(column_clock);
    @(posedge mclk);
    ce <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    check("column_clock_frozen", d1, 32'(column_clock));
    @(posedge mclk);
    ce <= 1'b1;
    sv = $random(seed);
    bus(1'b1, OFS_SETVAL, sv);
    for (int c = 0; c < 8; c++)
      bus(1'b1, OFS_SEC_BASE + 8'(4 * c), 32'(SEC_TBL[5*c +: 5]));
    rd(OFS_SEC_BASE + 8'h04, 32'h06);
    bus(1'b1, OFS_CTRL, 32'h1);
    rd(OFS_CTRL, 32'h1);
    check("config_done", 32'h1, 32'(config_done));
    bus(1'b1, OFS_SETVAL, ~sv);
    rd(OFS_SETVAL, sv);
    rd(OFS_CELLQ, sv);
    d1 = $random(seed);
    cell_d <= d1;
    p4 <= 8'hfd;
    repeat (3) @(posedge mclk);
    #1;
    exp = (d1 & 32'h0fff00ff) | (sv & ~32'h0fff00ff);
    check("cell_q", exp, cell_q);
    @(posedge mclk);
    p5 <= 8'hef;
    gsr_pin <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    check("cell_q", (exp & ~32'h00ff0000) | (sv & 32'h00ff0000), cell_q);
    @(posedge mclk);
    #1;
    check("cell_q", sv, cell_q);
    final_report();
  end
endmodule

bind column_clock_and_set_reset_distribution clkdist_chk #(.NCOL(NCOL),
  .SEC_PER_COL(SEC_PER_COL)) chk_inst (.mclk(mclk), .rstn(rstn), .av_req(av_req),
  .av_readdata(av_readdata), .av_waitrequest(av_waitrequest), .cell_q(cell_q),
  .config_done(config_done));
